// ---- cpuam_pkg.sv ----
package cpuam_pkg;
	localparam int unsigned CPUAM_CLK_HZ = 100000000;
	localparam logic [7:0] CPUAM_ZERO_PAGE = 8'h00;
	localparam logic [3:0] CPUAM_LEN_INH = 4'h1;
	localparam logic [3:0] CPUAM_LEN_IMM = 4'h2;
	localparam logic [3:0] CPUAM_LEN_DIR = 4'h2;
	localparam logic [3:0] CPUAM_LEN_EXT = 4'h3;
	localparam logic [3:0] CPUAM_LEN_IX = 4'h1;
	localparam logic [3:0] CPUAM_LEN_IX1 = 4'h2;
	localparam logic [3:0] CPUAM_LEN_IX2 = 4'h3;
	localparam logic [3:0] CPUAM_LEN_REL = 4'h2;
	localparam logic [3:0] CPUAM_LEN_BIT = 4'h2;

	typedef enum logic [2:0] {
		CPUAM_INH = 3'h0,
		CPUAM_IMM = 3'h1,
		CPUAM_DIR = 3'h2,
		CPUAM_EXT = 3'h3,
		CPUAM_IX = 3'h4,
		CPUAM_IX1 = 3'h5,
		CPUAM_IX2 = 3'h6,
		CPUAM_REL = 3'h7
	} cpuam_mode_e;

	typedef enum logic [3:0] {
		CPUAM_CL_REGMEM = 4'h0,
		CPUAM_CL_RMW = 4'h1,
		CPUAM_CL_TEST = 4'h2,
		CPUAM_CL_BIT_SET = 4'h3,
		CPUAM_CL_BIT_CLR = 4'h4,
		CPUAM_CL_BRANCH = 4'h5,
		CPUAM_CL_MUL = 4'h6,
		CPUAM_CL_STORE = 4'h7,
		CPUAM_CL_CTRL = 4'h8
	} cpuam_class_e;

	typedef enum logic [7:0] {
		CPUAM_ST_IDLE = 8'h01,
		CPUAM_ST_FETCH1 = 8'h02,
		CPUAM_ST_FETCH2 = 8'h04,
		CPUAM_ST_READ = 8'h08,
		CPUAM_ST_WRITE = 8'h10,
		CPUAM_ST_DONE = 8'h20
	} cpuam_state_e;

	typedef struct packed {
		cpuam_mode_e mode;
		cpuam_class_e cls;
		logic [2:0] alu_op;
		logic use_x;
		logic cond;
	} cpuam_instr_s;

	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} cpuam_bus_s;

	localparam logic [2:0] CPUAM_ALU_PASS = 3'h0;
	localparam logic [2:0] CPUAM_ALU_INC = 3'h1;
	localparam logic [2:0] CPUAM_ALU_DEC = 3'h2;
	localparam logic [2:0] CPUAM_ALU_COM = 3'h3;
	localparam logic [2:0] CPUAM_ALU_NEG = 3'h4;
	localparam logic [2:0] CPUAM_ALU_CLR = 3'h5;
	localparam logic [2:0] CPUAM_ALU_ADD = 3'h6;
	localparam logic [2:0] CPUAM_ALU_AND = 3'h7;
endpackage : cpuam_pkg

// ---- cpuam_ea.sv ----
`timescale 1ns/1ps
module cpuam_ea
	import cpuam_pkg::*;
(
	input wire cpuam_mode_e mode_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] op2_i,
	input wire logic [7:0] index_i,
	input wire logic [15:0] next_pc_i,
	output logic [15:0] ea_o,
	output logic [3:0] len_o
);
	always_comb begin
		ea_o = 16'h0000;
		len_o = CPUAM_LEN_INH;
		case (mode_i)
			CPUAM_INH: begin
				len_o = CPUAM_LEN_INH;
			end
			CPUAM_IMM: begin
				len_o = CPUAM_LEN_IMM;
			end
			// RULE3 zero high byte
			CPUAM_DIR: begin
				ea_o = {CPUAM_ZERO_PAGE, op1_i};
				len_o = CPUAM_LEN_DIR;
			end
			// RULE4 high byte first
			CPUAM_EXT: begin
				ea_o = {op1_i, op2_i};
				len_o = CPUAM_LEN_EXT;
			end
			// RULE5 index as low byte
			CPUAM_IX: begin
				ea_o = {CPUAM_ZERO_PAGE, index_i};
				len_o = CPUAM_LEN_IX;
			end
			// RULE6 nine-bit unsigned sum
			CPUAM_IX1: begin
				ea_o = {7'h00, {1'b0, index_i} + {1'b0, op1_i}};
				len_o = CPUAM_LEN_IX1;
			end
			CPUAM_IX2: begin
				// RULE7 RULE16 sum wraps in the 16-bit space
				ea_o = {op1_i, op2_i} + {8'h00, index_i};
				len_o = CPUAM_LEN_IX2;
			end
			// RULE9 sign-extended offset
			CPUAM_REL: begin
				ea_o = next_pc_i + {{8{op1_i[7]}}, op1_i};
				len_o = CPUAM_LEN_REL;
			end
			default: begin
				ea_o = 16'h0000;
			end
		endcase
	end
endmodule : cpuam_ea

// ---- cpuam_core.sv ----
`timescale 1ns/1ps
// Overview of operation
// RULE1: inherent opcodes are one byte, operands only from core registers
// RULE2: immediate opcodes are two bytes, second byte is literal operand
// RULE3: direct address is zero high byte plus the operand byte
// RULE4: extended takes three bytes, address high byte then low byte
// RULE5: indexed no offset is one byte, address is zero plus index
// RULE6: indexed 8-bit offset sums index and byte, nine-bit result
// RULE7: indexed 16-bit offset adds index to two-byte offset, high first
// RULE8: relative mode belongs only to branch instructions
// RULE9: taken branch adds sign-extended offset to next address, else falls through
// RULE10: register/memory ops combine a core register with memory operand
// RULE11: read-modify-write reads, modifies, writes back to same place
// RULE12: bit set and bit clear use direct addressing only
// RULE13: test-for-negative-or-zero reads and evaluates, skips write-back
// RULE14: software keeps read-modify-write away from write-only registers
// RULE15: unsigned multiply puts high byte in index, low in accumulator
// RULE16: 16-bit offset indexed addresses wrap modulo 65536
module cpuam_core
	import cpuam_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic start_i,
	input wire cpuam_instr_s instr_i,
	input wire logic [2:0] bit_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] op2_i,
	input wire logic [15:0] pc_i,
	input wire logic [7:0] rdata_i,
	output cpuam_bus_s bus_o,
	output logic [7:0] acc_o,
	output logic [7:0] index_o,
	output logic [15:0] next_pc_o,
	output logic [3:0] len_o,
	output logic illegal_o,
	output logic neg_o,
	output logic zero_o,
	output logic done_o
);
	cpuam_state_e state, next_state;
	cpuam_instr_s ins, next_ins;
	logic [7:0] o1, next_o1, o2, next_o2, acc, next_acc, idx, next_idx;
	logic [7:0] mem, next_mem;
	logic [2:0] bsel, next_bsel;
	logic [15:0] pc, next_pc;
	cpuam_bus_s bus, next_bus;
	logic [15:0] npc, next_npc_r;
	logic [3:0] len, next_len;
	logic ill, next_ill, neg, next_neg, zr, next_zr, dn, next_dn;
	logic [15:0] ea;
	logic [3:0] ea_len;
	logic [15:0] seq_pc;
	logic [15:0] prod;
	logic [7:0] res;

	function automatic logic [7:0] alu_f(input logic [2:0] op, input logic [7:0] a,
		input logic [7:0] m);
		case (op)
			CPUAM_ALU_INC: alu_f = a + 8'h01;
			CPUAM_ALU_DEC: alu_f = a - 8'h01;
			CPUAM_ALU_COM: alu_f = ~a;
			CPUAM_ALU_NEG: alu_f = 8'h00 - a;
			CPUAM_ALU_CLR: alu_f = 8'h00;
			CPUAM_ALU_ADD: alu_f = a + m;
			CPUAM_ALU_AND: alu_f = a & m;
			default: alu_f = m;
		endcase
	endfunction : alu_f

	cpuam_ea u_ea (
		.mode_i(ins.mode),
		.op1_i(o1),
		.op2_i(o2),
		.index_i(idx),
		.next_pc_i(seq_pc),
		.ea_o(ea),
		.len_o(ea_len)
	);

	assign seq_pc = pc + {12'h000, len};
	assign prod = 16'(acc) * 16'(idx);

	always_comb begin
		res = 8'h00;
		next_state = state;
		next_ins = ins;
		next_o1 = o1;
		next_o2 = o2;
		next_acc = acc;
		next_idx = idx;
		next_mem = mem;
		next_bsel = bsel;
		next_pc = pc;
		next_bus = bus;
		next_npc_r = npc;
		next_len = len;
		next_ill = ill;
		next_neg = neg;
		next_zr = zr;
		next_dn = 1'b0;
		next_bus.rd = 1'b0;
		next_bus.wr = 1'b0;
		case (state)
			CPUAM_ST_IDLE: begin
				if (start_i) begin
					next_ins = instr_i;
					next_o1 = op1_i;
					next_o2 = op2_i;
					next_pc = pc_i;
					next_bsel = bit_i;
					next_ill = 1'b0;
					next_state = CPUAM_ST_FETCH1;
				end
			end
			CPUAM_ST_FETCH1: begin
				next_len = ea_len;
				// RULE8 branch only relative
				if ((ins.mode == CPUAM_REL) != (ins.cls == CPUAM_CL_BRANCH))
					next_ill = 1'b1;
				// RULE12 bit ops direct
				if ((ins.cls == CPUAM_CL_BIT_SET || ins.cls == CPUAM_CL_BIT_CLR) &&
					ins.mode != CPUAM_DIR) begin
					next_ill = 1'b1;
					next_len = CPUAM_LEN_BIT;
				end
				next_state = CPUAM_ST_FETCH2;
			end
			CPUAM_ST_FETCH2: begin
				next_npc_r = seq_pc;
				if (ill) begin
					next_state = CPUAM_ST_DONE;
				end else if (ins.cls == CPUAM_CL_BRANCH) begin
					// RULE9 branch target
					next_npc_r = ins.cond ? ea : seq_pc;
					next_state = CPUAM_ST_DONE;
				end else if (ins.cls == CPUAM_CL_MUL) begin
					// RULE15 product split
					next_idx = prod[15:8];
					next_acc = prod[7:0];
					next_state = CPUAM_ST_DONE;
				end else if (ins.mode == CPUAM_INH) begin
					// RULE1 register operand
					next_mem = ins.use_x ? idx : acc;
					next_state = CPUAM_ST_READ;
				end else if (ins.mode == CPUAM_IMM) begin
					// RULE2 literal operand
					next_mem = o1;
					next_state = CPUAM_ST_READ;
				end else if (ins.cls == CPUAM_CL_STORE) begin
					next_bus.addr = ea;
					next_bus.wr = 1'b1;
					next_bus.wdata = ins.use_x ? idx : acc;
					next_state = CPUAM_ST_DONE;
				end else begin
					// RULE3 RULE4 RULE5 RULE6 RULE7 RULE16 memory operand fetch
					next_bus.addr = ea;
					next_bus.rd = 1'b1;
					next_state = CPUAM_ST_WRITE;
				end
			end
			CPUAM_ST_WRITE: begin
				next_mem = rdata_i;
				next_state = CPUAM_ST_READ;
			end
			CPUAM_ST_READ: begin
				next_state = CPUAM_ST_DONE;
				case (ins.cls)
					CPUAM_CL_REGMEM: begin
						// RULE10 register with memory
						if (ins.use_x)
							next_idx = alu_f(ins.alu_op, idx, mem);
						else
							next_acc = alu_f(ins.alu_op, acc, mem);
					end
					CPUAM_CL_TEST: begin
						// RULE13 evaluate without write-back
						next_neg = mem[7];
						next_zr = (mem == 8'h00);
					end
					CPUAM_CL_BIT_SET, CPUAM_CL_BIT_CLR, CPUAM_CL_RMW: begin
						// RULE11 write back to source
						res = alu_f(ins.alu_op, mem, mem);
						if (ins.cls == CPUAM_CL_BIT_SET)
							res = mem | (8'h01 << bsel);
						if (ins.cls == CPUAM_CL_BIT_CLR)
							res = mem & ~(8'h01 << bsel);
						next_neg = res[7];
						next_zr = (res == 8'h00);
						if (ins.mode == CPUAM_INH) begin
							if (ins.use_x)
								next_idx = res;
							else
								next_acc = res;
						end else begin
							next_bus.wr = 1'b1;
							next_bus.wdata = res;
						end
					end
					default: begin
					end
				endcase
			end
			CPUAM_ST_DONE: begin
				next_dn = 1'b1;
				next_state = CPUAM_ST_IDLE;
			end
			default: begin
				next_state = CPUAM_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= CPUAM_ST_IDLE;
			ins <= '0;
			o1 <= 8'h00;
			o2 <= 8'h00;
			acc <= 8'h00;
			idx <= 8'h00;
			mem <= 8'h00;
			bsel <= 3'h0;
			pc <= 16'h0000;
			bus <= '0;
			npc <= 16'h0000;
			len <= 4'h0;
			ill <= 1'b0;
			neg <= 1'b0;
			zr <= 1'b0;
			dn <= 1'b0;
		end else begin
			state <= next_state;
			ins <= next_ins;
			o1 <= next_o1;
			o2 <= next_o2;
			acc <= next_acc;
			idx <= next_idx;
			mem <= next_mem;
			bsel <= next_bsel;
			pc <= next_pc;
			bus <= next_bus;
			npc <= next_npc_r;
			len <= next_len;
			ill <= next_ill;
			neg <= next_neg;
			zr <= next_zr;
			dn <= next_dn;
		end
	end

	assign bus_o = bus;
	assign acc_o = acc;
	assign index_o = idx;
	assign next_pc_o = npc;
	assign len_o = len;
	assign illegal_o = ill;
	assign neg_o = neg;
	assign zero_o = zr;
	assign done_o = dn;

	// RULE13 no write for test
	property p_test_no_write;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(state == CPUAM_ST_READ && ins.cls == CPUAM_CL_TEST) |=> !bus.wr;
	endproperty
	a_test_no_write: assert property (p_test_no_write) else $error("test wrote back"); // RULE13
	// RULE11 write to read address
	property p_rmw_same;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(bus.rd && ins.cls == CPUAM_CL_RMW) |=> ##1 (bus.wr && bus.addr == $past(bus.addr, 2));
	endproperty
	a_rmw_same: assert property (p_rmw_same) else $error("rmw address changed"); // RULE11
	// RULE3 direct zero page
	property p_dir_page;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(bus.rd && ins.mode == CPUAM_DIR) |-> (bus.addr == {8'h00, o1});
	endproperty
	a_dir_page: assert property (p_dir_page) else $error("direct page wrong"); // RULE3
	// RULE6 nine bit index sum
	property p_ix1_sum;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(bus.rd && ins.mode == CPUAM_IX1) |-> (bus.addr == {8'h00, o1} + {8'h00, idx});
	endproperty
	a_ix1_sum: assert property (p_ix1_sum) else $error("ix1 address wrong"); // RULE6
	// RULE9 branch target
	property p_branch;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(state == CPUAM_ST_FETCH2 && ins.cls == CPUAM_CL_BRANCH && !ill && ins.cond) |=>
		(npc == pc + 16'h0002 + {{8{o1[7]}}, o1});
	endproperty
	a_branch: assert property (p_branch) else $error("branch target wrong"); // RULE9
	// RULE12 bit op illegal
	property p_bit_dir;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(state == CPUAM_ST_FETCH1 && ins.cls == CPUAM_CL_BIT_SET && ins.mode != CPUAM_DIR)
		|=> ill ##1 !bus.wr;
	endproperty
	a_bit_dir: assert property (p_bit_dir) else $error("bit op not flagged"); // RULE12
	// RULE15 multiply
	property p_mul;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(state == CPUAM_ST_FETCH2 && ins.cls == CPUAM_CL_MUL && !ill) |=>
		({idx, acc} == 16'($past(acc)) * 16'($past(idx)));
	endproperty
	a_mul: assert property (p_mul) else $error("multiply wrong"); // RULE15
	// RULE4 extended length
	property p_ext_len;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(state == CPUAM_ST_FETCH1 && ins.mode == CPUAM_EXT && ins.cls != CPUAM_CL_BIT_SET &&
		ins.cls != CPUAM_CL_BIT_CLR) |=> (len == 4'h3);
	endproperty
	a_ext_len: assert property (p_ext_len) else $error("ext length wrong"); // RULE4
	c_branch: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		state == CPUAM_ST_FETCH2 && ins.cls == CPUAM_CL_BRANCH);
	c_rmw: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		bus.wr && ins.cls == CPUAM_CL_RMW);
	c_ill: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) ill && dn);
endmodule : cpuam_core

// ---- cpuam_mem_model.sv ----
`timescale 1ns/1ps
module cpuam_mem_model
	import cpuam_pkg::*;
(
	input wire logic clk_sys_i,
	input wire cpuam_bus_s bus_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [65536];
	int n_rd = 0;
	int n_wr = 0;
	logic [15:0] last_raddr = 16'h0000;
	logic [15:0] last_waddr = 16'h0000;
	logic [7:0] last_wdata = 8'h00;
	// core takes read data in the cycle its read strobe stands
	// an idle bus shows the inverse so stale data never looks fresh
	assign rdata_o = bus_i.rd ? mem[bus_i.addr] : ~mem[bus_i.addr];
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i ^ (i >> 8) ^ 8'ha5);
		end
	end
	always @(posedge clk_sys_i) begin
		if (bus_i.rd) begin
			n_rd <= n_rd + 1;
			last_raddr <= bus_i.addr;
		end
		if (bus_i.wr) begin
			mem[bus_i.addr] <= bus_i.wdata;
			n_wr <= n_wr + 1;
			last_waddr <= bus_i.addr;
			last_wdata <= bus_i.wdata;
		end
	end
endmodule : cpuam_mem_model

// ---- test_cpu_addressing_mode_logic.sv ----
`timescale 1ns/1ps
module test_cpu_addressing_mode_logic;
	import cpuam_pkg::*;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic start_i = 1'b0;
	cpuam_instr_s instr_i = '0;
	logic [2:0] bit_i = 3'h0;
	logic [7:0] op1_i = 8'h00;
	logic [7:0] op2_i = 8'h00;
	logic [15:0] pc_i = 16'h0000;
	logic [7:0] rdata;
	cpuam_bus_s bus;
	logic [7:0] acc_o;
	logic [7:0] index_o;
	logic [15:0] next_pc_o;
	logic [3:0] len_o;
	logic illegal_o;
	logic neg_o;
	logic zero_o;
	logic done_o;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [7:0] acc = 8'h00;
	logic [7:0] idx = 8'h00;
	logic [7:0] wmem [int];
	cpuam_class_e tab [6] = '{CPUAM_CL_REGMEM, CPUAM_CL_RMW, CPUAM_CL_TEST, CPUAM_CL_STORE,
		CPUAM_CL_BIT_SET, CPUAM_CL_BRANCH};

	always #5 clk_sys_i = ~clk_sys_i;

	cpuam_core dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .start_i(start_i),
		.instr_i(instr_i), .bit_i(bit_i), .op1_i(op1_i), .op2_i(op2_i), .pc_i(pc_i),
		.rdata_i(rdata), .bus_o(bus), .acc_o(acc_o), .index_o(index_o),
		.next_pc_o(next_pc_o), .len_o(len_o), .illegal_o(illegal_o), .neg_o(neg_o),
		.zero_o(zero_o), .done_o(done_o));
	cpuam_mem_model mem_model (.clk_sys_i(clk_sys_i), .bus_i(bus), .rdata_o(rdata));

	function automatic logic [7:0] mem_rd(input logic [15:0] a);
		if (wmem.exists(int'(a))) return wmem[int'(a)];
		return a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction : mem_rd

	function automatic logic [3:0] len_f(input cpuam_mode_e m, input cpuam_class_e c);
		if (c == CPUAM_CL_BIT_SET || c == CPUAM_CL_BIT_CLR) return CPUAM_LEN_BIT;
		case (m)
			CPUAM_INH: return CPUAM_LEN_INH;
			CPUAM_IMM: return CPUAM_LEN_IMM;
			CPUAM_DIR: return CPUAM_LEN_DIR;
			CPUAM_EXT: return CPUAM_LEN_EXT;
			CPUAM_IX: return CPUAM_LEN_IX;
			CPUAM_IX1: return CPUAM_LEN_IX1;
			CPUAM_IX2: return CPUAM_LEN_IX2;
			default: return CPUAM_LEN_REL;
		endcase
	endfunction : len_f

	// a is the register or the modified value, m the operand; unlisted ops pass m
	function automatic logic [7:0] alu_f(input logic [2:0] op, input logic [7:0] a,
		input logic [7:0] m);
		case (op)
			CPUAM_ALU_INC: return a + 8'h01;
			CPUAM_ALU_DEC: return a - 8'h01;
			CPUAM_ALU_COM: return ~a;
			CPUAM_ALU_NEG: return 8'h00 - a;
			CPUAM_ALU_CLR: return 8'h00;
			CPUAM_ALU_ADD: return a + m;
			CPUAM_ALU_AND: return a & m;
			default: return m;
		endcase
	endfunction : alu_f

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic chk_mode(input logic [3:0] l, input logic mo, input logic st,
		input logic [15:0] ea);
		chk("len", 16'(l), 16'(len_o));
		if (mo) chk("addr", ea, st ? mem_model.last_waddr : mem_model.last_raddr);
	endtask : chk_mode

	task automatic run(input cpuam_mode_e m, input cpuam_class_e c, input logic [2:0] alu,
		input logic ux, input logic cd, input logic [7:0] o1, input logic [7:0] o2);
		logic [15:0] pc;
		logic [15:0] ea;
		logic [15:0] nxt;
		logic [7:0] v;
		logic [7:0] r;
		logic [2:0] b;
		logic ill;
		logic mo;
		logic st;
		int rd0;
		int wr0;
		int nw;
		int k;
		pc = 16'($urandom);
		b = 3'($urandom);
		rd0 = mem_model.n_rd;
		wr0 = mem_model.n_wr;
		st = c == CPUAM_CL_STORE;
		ill = ((m == CPUAM_REL) != (c == CPUAM_CL_BRANCH)) ||
			((c == CPUAM_CL_BIT_SET || c == CPUAM_CL_BIT_CLR) && m != CPUAM_DIR);
		mo = !(m inside {CPUAM_INH, CPUAM_IMM, CPUAM_REL}) && !ill;
		case (m)
			CPUAM_DIR: ea = {8'h00, o1};
			CPUAM_EXT: ea = {o1, o2};
			CPUAM_IX: ea = {8'h00, idx};
			CPUAM_IX1: ea = 16'(idx) + 16'(o1);
			CPUAM_IX2: ea = {o1, o2} + 16'(idx);
			default: ea = 16'h0000;
		endcase
		v = m == CPUAM_IMM ? o1 : m == CPUAM_INH ? (ux ? idx : acc) : mem_rd(ea);
		r = v;
		nw = 0;
		nxt = pc + 16'(len_f(m, c));
		if (c == CPUAM_CL_BRANCH && cd) nxt = nxt + {{8{o1[7]}}, o1};
		if (!ill) begin
			case (c)
				CPUAM_CL_REGMEM: begin
					r = alu_f(alu, ux ? idx : acc, v);
					if (ux) idx = r;
					else acc = r;
				end
				CPUAM_CL_RMW: r = alu_f(alu, v, v);
				CPUAM_CL_BIT_SET: r = v | (8'h01 << b);
				CPUAM_CL_BIT_CLR: r = v & ~(8'h01 << b);
				CPUAM_CL_MUL: {idx, acc} = 16'(acc) * 16'(idx);
				CPUAM_CL_STORE: r = ux ? idx : acc;
				default: ;
			endcase
			if (c inside {CPUAM_CL_RMW, CPUAM_CL_BIT_SET, CPUAM_CL_BIT_CLR, CPUAM_CL_STORE}) begin
				if (m != CPUAM_INH) wmem[int'(ea)] = r;
				if (m != CPUAM_INH) nw = 1;
				else if (ux) idx = r;
				else acc = r;
			end
		end
		@(posedge clk_sys_i);
		#1;
		instr_i = '{mode: m, cls: c, alu_op: alu, use_x: ux, cond: cd};
		op1_i = o1;
		op2_i = o2;
		pc_i = pc;
		bit_i = b;
		start_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		start_i = 1'b0;
		for (k = 0; k < 12 && done_o !== 1'b1; k++) begin
			@(posedge clk_sys_i);
			#1;
		end
		chk("done", 16'h0001, 16'(done_o));
		chk("illegal", 16'(ill), 16'(illegal_o));
		if (ill) begin
			chk("bus", 16'h0000, 16'(mem_model.n_rd - rd0 + mem_model.n_wr - wr0));
			return;
		end
		case (m)
			CPUAM_INH: chk_mode(len_f(m, c), mo, st, ea);
			CPUAM_IMM: chk_mode(len_f(m, c), mo, st, ea);
			CPUAM_DIR: chk_mode(len_f(m, c), mo, st, ea);
			CPUAM_EXT: chk_mode(len_f(m, c), mo, st, ea);
			CPUAM_IX: chk_mode(len_f(m, c), mo, st, ea);
			CPUAM_IX1: chk_mode(len_f(m, c), mo, st, ea);
			CPUAM_IX2: chk_mode(len_f(m, c), mo, st, ea);
			default: chk_mode(len_f(m, c), mo, st, ea);
		endcase
		chk("acc", 16'(acc), 16'(acc_o));
		chk("index", 16'(idx), 16'(index_o));
		chk("next_pc", nxt, next_pc_o);
		if (!st) chk("reads", 16'(mo), 16'(mem_model.n_rd - rd0));
		chk("writes", 16'(nw), 16'(mem_model.n_wr - wr0));
		if (nw > 0) chk("wdata", 16'(r), 16'(mem_model.last_wdata));
		if (nw > 0) chk("waddr", ea, mem_model.last_waddr);
		if (c inside {CPUAM_CL_RMW, CPUAM_CL_TEST}) chk("flags", {14'h0, r[7], r == 8'h00},
			{14'h0, neg_o, zero_o});
	endtask : run

	task automatic complete_run;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		cpuam_class_e c;
		cpuam_mode_e m;
		logic [2:0] al;
		logic ux;
		void'($urandom(38));
		repeat (10) @(posedge clk_sys_i);
		#1;
		arst_n_i = 1'b1;
		run(CPUAM_IMM, CPUAM_CL_REGMEM, CPUAM_ALU_PASS, 1'b1, 1'b0, 8'hff, 8'h00);
		run(CPUAM_IX1, CPUAM_CL_REGMEM, CPUAM_ALU_PASS, 1'b0, 1'b0, 8'hff, 8'h00);
		run(CPUAM_IX2, CPUAM_CL_REGMEM, CPUAM_ALU_ADD, 1'b0, 1'b0, 8'hff, 8'hf0);
		run(CPUAM_INH, CPUAM_CL_MUL, CPUAM_ALU_PASS, 1'b0, 1'b0, 8'h00, 8'h00);
		run(CPUAM_DIR, CPUAM_CL_TEST, CPUAM_ALU_PASS, 1'b0, 1'b0, 8'h40, 8'h00);
		run(CPUAM_DIR, CPUAM_CL_BIT_CLR, CPUAM_ALU_PASS, 1'b0, 1'b0, 8'h12, 8'h00);
		run(CPUAM_EXT, CPUAM_CL_BIT_SET, CPUAM_ALU_PASS, 1'b0, 1'b0, 8'h12, 8'h34);
		run(CPUAM_REL, CPUAM_CL_BRANCH, CPUAM_ALU_PASS, 1'b0, 1'b1, 8'h80, 8'h00);
		run(CPUAM_REL, CPUAM_CL_BRANCH, CPUAM_ALU_PASS, 1'b0, 1'b0, 8'h7f, 8'h00);
		run(CPUAM_REL, CPUAM_CL_REGMEM, CPUAM_ALU_PASS, 1'b0, 1'b0, 8'h10, 8'h00);
		run(CPUAM_DIR, CPUAM_CL_BRANCH, CPUAM_ALU_PASS, 1'b0, 1'b1, 8'h10, 8'h00);
		for (int a = 1; a < 6; a++) begin
			run(CPUAM_INH, CPUAM_CL_RMW, 3'(a), 1'(a), 1'b0, 8'h00, 8'h00);
			run(CPUAM_IX, CPUAM_CL_RMW, 3'(a), 1'b0, 1'b0, 8'h00, 8'h00);
		end
		// model memory has no write-only places
		repeat (80) begin
			c = tab[$urandom_range(5, 0)];
			m = c == CPUAM_CL_BRANCH ? CPUAM_REL : cpuam_mode_e'($urandom_range(6, 2));
			al = 3'($urandom_range(7, 0));
			ux = 1'($urandom_range(1, 0));
			if (c == CPUAM_CL_RMW) al = 3'($urandom_range(5, 1));
			if (al >= 3'h6) ux = 1'b0;
			run(m, c, al, ux, 1'($urandom), 8'($urandom), 8'($urandom));
		end
		complete_run();
	end

	initial begin
		#100000;
		n_mismatch++;
		complete_run();
	end
endmodule : test_cpu_addressing_mode_logic
